// File: hw/apb_reg_port.sv
// APB slave that decodes the three registers of the flag core
`timescale 1ns/100ps
`default_nettype none
module apb_reg_port #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	reg_access_if.bus regs
);
	import aux_irq_pkg::*;

	reg_sel_t sel;
	logic [31:0] prdata_r;

	// Address decode, full byte address so misaligned accesses miss
	always_comb begin
		if (paddr == ADDR_W'(OFS_FLAGS))
			sel = SEL_FLAGS;
		else if (paddr == ADDR_W'(OFS_ENABLES))
			sel = SEL_ENABLES;
		else if (paddr == ADDR_W'(OFS_VECTOR))
			sel = SEL_VECTOR;
		else
			sel = SEL_NONE;
	end

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel & penable & (sel == SEL_NONE);

	// Write strobe at the access edge only
	assign regs.wr_stb = psel & penable & pwrite & (sel != SEL_NONE);
	assign regs.wr_sel = sel;
	assign regs.wdata = pwdata[15:0];

	// Read data captured in the setup cycle, upper half zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (sel)
				SEL_FLAGS: prdata_r <= {16'h0000, regs.rd_flags};
				SEL_ENABLES: prdata_r <= {16'h0000, regs.rd_enables};
				SEL_VECTOR: prdata_r <= {16'h0000, regs.rd_vector};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end
	assign prdata = prdata_r;

endmodule // apb_reg_port
`default_nettype wire

// File: hw/aux_irq_pkg.sv
// Constants and types shared by the supply event interrupt logic
package aux_irq_pkg;

	// Register byte offsets on the APB word map
	localparam int OFS_FLAGS = 32'h0000_0000;
	localparam int OFS_ENABLES = 32'h0000_0004;
	localparam int OFS_VECTOR = 32'h0000_0008;

	// Register width and reset value
	localparam int REG_W = 16;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// Bit positions shared by the flag and enable registers
	localparam int BIT_TO_PRIMARY = 0;
	localparam int BIT_TO_FIRST = 1;
	localparam int BIT_TO_SECOND = 2;
	localparam int BIT_GLOBAL_EN = 3;
	localparam int BIT_SPARE = 4;
	localparam int BIT_FIRST_DROP = 5;
	localparam int BIT_SECOND_DROP = 6;
	localparam int BIT_MONITOR = 7;
	localparam int BIT_GLOBAL = 8;

	// Software writable bits of each register
	localparam logic [15:0] FLAGS_WR_MASK = 16'h01F7;
	localparam logic [15:0] ENABLES_WR_MASK = 16'h00FF;
	// Flags that request a maskable interrupt with their own enable
	localparam logic [15:0] LOCAL_SRC_MASK = 16'h00E7;

	// Vector codes, highest priority first
	localparam logic [15:0] VEC_NONE = 16'h0000;
	localparam logic [15:0] VEC_GLOBAL = 16'h0002;
	localparam logic [15:0] VEC_TO_PRIMARY = 16'h0004;
	localparam logic [15:0] VEC_TO_FIRST = 16'h0006;
	localparam logic [15:0] VEC_TO_SECOND = 16'h0008;
	localparam logic [15:0] VEC_FIRST_DROP = 16'h000C;
	localparam logic [15:0] VEC_SECOND_DROP = 16'h000E;
	localparam logic [15:0] VEC_MONITOR = 16'h0010;

	// Which supply powers the device
	typedef enum logic [1:0] {
		SUPPLY_PRIMARY = 2'b00,
		SUPPLY_FIRST = 2'b01,
		SUPPLY_SECOND = 2'b10,
		SUPPLY_NONE = 2'b11
	} supply_t;

	// Register selected by a bus access
	typedef enum logic [1:0] {
		SEL_FLAGS = 2'b00,
		SEL_ENABLES = 2'b01,
		SEL_VECTOR = 2'b10,
		SEL_NONE = 2'b11
	} reg_sel_t;

endpackage

// File: hw/aux_supply_irq_flags.sv
// Supply event flags, enables, vector and interrupt requests
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module aux_supply_irq_flags #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire aux_irq_pkg::supply_t active_supply,
	input wire logic first_drop_stb,
	input wire logic second_drop_stb,
	input wire logic monitor_done_stb,
	input wire logic nmi_enable_cfg,
	input wire logic cpu_interrupt_master_enable,
	output logic nmi_req,
	output logic irq_req,
	output logic [15:0] vector_out
);
	import aux_irq_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Parameter check

	// The decoder needs room for all three word offsets
	if (ADDR_W < 4) begin : g_addr_check
		$error("ADDR_W too small for the register map");
	end

	// Offsets are held in int constants, so the bus stays within 32 bits
	if (ADDR_W > 32) begin : g_addr_wide_check
		$error("ADDR_W wider than the offset constants");
	end

	// Every register is one half word throughout the datapath
	if (REG_W != 16) begin : g_width_check
		$error("REG_W must be 16");
	end

	// Flag bit 3 always reads zero, so it must never be stored
	if (FLAGS_WR_MASK[BIT_GLOBAL_EN]) begin : g_flag_mask_check
		$error("flag bit 3 must not be writable");
	end

	// Enable bit 8 mirrors the system setting, never software
	if (ENABLES_WR_MASK[BIT_GLOBAL]) begin : g_enable_mask_check
		$error("enable bit 8 must not be writable");
	end

	// The global flag has its own request path with two enables
	if (LOCAL_SRC_MASK[BIT_GLOBAL] || LOCAL_SRC_MASK[BIT_GLOBAL_EN]) begin : g_local_mask_check
		$error("global bits must not be local sources");
	end

	// The spare bit is stored but must never request
	if (LOCAL_SRC_MASK[BIT_SPARE]) begin : g_spare_check
		$error("spare bit must not be a source");
	end

	// The decoder compares full byte addresses of aligned words
	if ((OFS_FLAGS % 4) != 0 || (OFS_ENABLES % 4) != 0 || (OFS_VECTOR % 4) != 0) begin : g_align_check
		$error("register offsets must be word aligned");
	end

	// Two registers on one offset would shadow each other
	if (OFS_FLAGS == OFS_ENABLES || OFS_FLAGS == OFS_VECTOR || OFS_ENABLES == OFS_VECTOR) begin : g_ofs_check
		$error("register offsets must differ");
	end

	// Every offset must be reachable on the address bus
	if (ADDR_W < 32 && OFS_VECTOR >= (1 << ADDR_W)) begin : g_reach_check
		$error("vector offset beyond the address width");
	end

	////////////////////////////////////////////////////////////////////
	// Declarations

	reg_access_if regs ();

	logic [15:0] flags_r;
	logic [15:0] flags_nxt;
	logic [15:0] enables_r;
	logic [15:0] enables_nxt;
	logic [15:0] set_evt;
	logic [15:0] pending;
	logic [15:0] vector_nxt;
	logic [15:0] vector_r;
	supply_t prev_supply_r;
	logic supply_known_r;
	logic supply_changed;
	logic nmi_req_r;
	logic irq_req_r;
	logic nmi_req_nxt;
	logic irq_req_nxt;
	logic global_maskable;
	logic local_any;

	////////////////////////////////////////////////////////////////////
	// Bus port

	apb_reg_port #(
		.ADDR_W(ADDR_W)
	) u_bus (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.regs(regs.bus)
	);

	////////////////////////////////////////////////////////////////////
	// Supply tracking

	// First cycle after reset with a valid supply only learns the start-up supply, so
	// the choice made at power-up does not look like a switch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_known_r <= 1'b0;
		end else if (active_supply != SUPPLY_NONE) begin
			supply_known_r <= 1'b1;
		end
	end

	// Last valid supply seen; the undefined code is never recorded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_supply_r <= SUPPLY_PRIMARY;
		end else if (active_supply != SUPPLY_NONE) begin
			prev_supply_r <= active_supply;
		end
	end

	// A change between two valid supplies
	// The undefined code in between is skipped, so primary, none, first
	// still counts as one switch into the first backup
	// No change is reported while the start-up supply is being learnt
	assign supply_changed = supply_known_r && (active_supply != SUPPLY_NONE)
		&& (active_supply != prev_supply_r);

	////////////////////////////////////////////////////////////////////
	// Hardware set events

	// Event vector in flag bit order
	always_comb begin
		set_evt = REG_RESET;
		set_evt[BIT_GLOBAL] = supply_changed;
		set_evt[BIT_MONITOR] = monitor_done_stb;
		set_evt[BIT_SECOND_DROP] = second_drop_stb;
		set_evt[BIT_FIRST_DROP] = first_drop_stb;
		set_evt[BIT_TO_SECOND] = supply_changed && (active_supply == SUPPLY_SECOND);
		set_evt[BIT_TO_FIRST] = supply_changed && (active_supply == SUPPLY_FIRST);
		set_evt[BIT_TO_PRIMARY] = supply_changed && (active_supply == SUPPLY_PRIMARY);
	end

	////////////////////////////////////////////////////////////////////
	// Flag register

	// Software write, vector clear, then hardware sets on top
	// Writing a one by software sets a flag, which lets a handler
	// raise a request on purpose; writing zero clears it
	// The spare bit 4 is stored as written but requests nothing
	// Ordering the OR last makes a same-cycle event survive any clear
	always_comb begin
		flags_nxt = flags_r;
		if (regs.wr_stb && regs.wr_sel == SEL_FLAGS) begin
			flags_nxt = regs.wdata & FLAGS_WR_MASK;
		end
		if (regs.wr_stb && regs.wr_sel == SEL_VECTOR) begin
			flags_nxt = REG_RESET;
		end
		flags_nxt = flags_nxt | set_evt;
	end

	// Flags reset to none pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= REG_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Enable register

	// Software owns bits 7..0; bit 8 follows the system setting
	// Bit 8 lags its input by one clock, as any other stored bit
	// A software write to bit 8 is dropped by the write mask
	always_comb begin
		enables_nxt = enables_r;
		if (regs.wr_stb && regs.wr_sel == SEL_ENABLES) begin
			enables_nxt = regs.wdata & ENABLES_WR_MASK;
		end
		enables_nxt[BIT_GLOBAL] = nmi_enable_cfg;
	end

	// Enables reset to all disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enables_r <= REG_RESET;
		end else begin
			enables_r <= enables_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pending sources and vector

	// A source counts once its flag and its enable are both set;
	// the global flag counts under either of its two enables
	// Disabled flags stay readable but are left out of the vector,
	// so a handler only ever sees codes it can service
	always_comb begin
		pending = flags_r & enables_r & LOCAL_SRC_MASK;
		pending[BIT_GLOBAL] = flags_r[BIT_GLOBAL]
			& (enables_r[BIT_GLOBAL] | enables_r[BIT_GLOBAL_EN]);
	end

	irq_vector_enc u_vec (
		.pending(pending),
		.vector(vector_nxt)
	);

	// Vector held in a flop for the read path and the output port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_r <= VEC_NONE;
		end else begin
			vector_r <= vector_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt requests

	assign nmi_req_nxt = flags_r[BIT_GLOBAL] & enables_r[BIT_GLOBAL];

	assign global_maskable = flags_r[BIT_GLOBAL] & ~enables_r[BIT_GLOBAL]
		& enables_r[BIT_GLOBAL_EN];

	assign local_any = |(flags_r & enables_r & LOCAL_SRC_MASK);

	// Maskable line honours the processor's master enable
	// The non-maskable line ignores it, as a switch must never be lost
	assign irq_req_nxt = cpu_interrupt_master_enable & (global_maskable | local_any);

	// Requests registered so the outputs come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_req_r <= 1'b0;
			irq_req_r <= 1'b0;
		end else begin
			nmi_req_r <= nmi_req_nxt;
			irq_req_r <= irq_req_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs and read-back

	// Requests and vector come from flops built on the same flag state,
	// so they change together two clocks after an event
	// Reading the vector has no side effect; only a write clears
	assign nmi_req = nmi_req_r;
	assign irq_req = irq_req_r;
	assign vector_out = vector_r;

	assign regs.rd_flags = flags_r & FLAGS_WR_MASK;
	assign regs.rd_enables = enables_r & (ENABLES_WR_MASK | (16'h0001 << BIT_GLOBAL));
	assign regs.rd_vector = vector_r;

endmodule // aux_supply_irq_flags
`default_nettype wire

// File: hw/irq_vector_enc.sv
// Priority encoder from pending sources to the vector code
`timescale 1ns/100ps
`default_nettype none
module irq_vector_enc (
	input wire logic [15:0] pending,
	output logic [15:0] vector
);
	import aux_irq_pkg::*;

	// Global switch first, supply monitor last
	always_comb begin
		if (pending[BIT_GLOBAL])
			vector = VEC_GLOBAL;
		else if (pending[BIT_TO_PRIMARY])
			vector = VEC_TO_PRIMARY;
		else if (pending[BIT_TO_FIRST])
			vector = VEC_TO_FIRST;
		else if (pending[BIT_TO_SECOND])
			vector = VEC_TO_SECOND;
		else if (pending[BIT_FIRST_DROP])
			vector = VEC_FIRST_DROP;
		else if (pending[BIT_SECOND_DROP])
			vector = VEC_SECOND_DROP;
		else if (pending[BIT_MONITOR])
			vector = VEC_MONITOR;
		else
			vector = VEC_NONE;
	end

endmodule // irq_vector_enc
`default_nettype wire

// File: hw/reg_access_if.sv
// Register access carrier between the APB port and the flag core
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
	import aux_irq_pkg::*;
	logic wr_stb;
	reg_sel_t wr_sel;
	logic [15:0] wdata;
	logic [15:0] rd_flags;
	logic [15:0] rd_enables;
	logic [15:0] rd_vector;

	// Bus side issues writes and reads register contents
	modport bus (output wr_stb, output wr_sel, output wdata,
		input rd_flags, input rd_enables, input rd_vector);
	// Core side stores writes and shows its state
	modport core (input wr_stb, input wr_sel, input wdata,
		output rd_flags, output rd_enables, output rd_vector);
endinterface
`default_nettype wire

// File: tb/aux_irq_flags_sva.sv
// Port checker for the supply event interrupt block
`timescale 1ns/100ps
`default_nettype none
module aux_irq_flags_sva #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire aux_irq_pkg::supply_t active_supply,
	input wire logic first_drop_stb,
	input wire logic second_drop_stb,
	input wire logic monitor_done_stb,
	input wire logic nmi_enable_cfg,
	input wire logic cpu_interrupt_master_enable,
	input wire logic nmi_req,
	input wire logic irq_req,
	input wire logic [15:0] vector_out
);
	import aux_irq_pkg::*;
	////////////////////////////////////////
	// Access phase decodes
	wire logic acc = psel && penable;
	wire logic rd_f = acc && !pwrite && paddr == OFS_FLAGS;
	wire logic rd_e = acc && !pwrite && paddr == OFS_ENABLES;
	wire logic clr = acc && pwrite && paddr == OFS_VECTOR;
	wire logic quiet = !first_drop_stb && !second_drop_stb && !monitor_done_stb;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_switch_nmi: assert property ($past(presetn, 2) && nmi_enable_cfg
		&& active_supply != $past(active_supply) && active_supply != SUPPLY_NONE
		&& $past(active_supply) != SUPPLY_NONE |-> ##2 nmi_req) else $error("nmi missing");
	a_irq_gate: assert property (irq_req |-> $past(cpu_interrupt_master_enable))
		else $error("irq without cpu enable");
	a_nmi_vec: assert property (nmi_req |-> vector_out == VEC_GLOBAL)
		else $error("nmi vector");
	a_req_vec: assert property (irq_req |-> vector_out != VEC_NONE)
		else $error("irq with empty vector");
	a_vec_clr: assert property (clr && quiet && $stable(active_supply)
		|-> ##2 vector_out == VEC_NONE && !irq_req && !nmi_req) else $error("flags kept");
	a_flag_rsv: assert property (rd_f |-> prdata[31:9] == 0 && !prdata[3])
		else $error("flag reserved bits");
	a_en_rsv: assert property ($past(presetn, 2) && rd_e
		|-> prdata[31:9] == 0 && prdata[8] == $past(nmi_enable_cfg, 2)) else $error("enables");
	a_err_map: assert property (acc && paddr > OFS_VECTOR |-> pslverr) else $error("no error");
	a_err_phase: assert property (pslverr |-> acc) else $error("error outside access");
	c_nmi: cover property (nmi_req);
	c_irq: cover property (irq_req);
	c_err: cover property (pslverr);
endmodule // aux_irq_flags_sva
bind aux_supply_irq_flags aux_irq_flags_sva #(.ADDR_W(ADDR_W)) sva (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pslverr, .active_supply, .first_drop_stb,
	.second_drop_stb, .monitor_done_stb, .nmi_enable_cfg, .cpu_interrupt_master_enable,
	.nmi_req, .irq_req, .vector_out);
`default_nettype wire

// File: tb/cpu_model.sv
// Processor model: registered master interrupt enable
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sw_enable,
	output logic master_enable
);
	////////////////////////////////////////
	// Software sets the master enable, seen one clock later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			master_enable <= 1'b0;
		else
			master_enable <= sw_enable;
	end
endmodule // cpu_model
`default_nettype wire

// File: tb/test_aux_supply_irq_flags.sv
// Self-checking bench for the supply event interrupt block
`timescale 1ns/100ps
`default_nettype none
module test_aux_supply_irq_flags;
	import aux_irq_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, master_enable, nmi, irq;
	logic cfg = 0, sw_enable = 0;
	logic [2:0] stb = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic [15:0] vec, ef = 0, rnd = 16'h0014;
	supply_t sup = SUPPLY_PRIMARY;
	logic [31:0] q[$];
	logic [15:0] codes[7] = '{VEC_TO_PRIMARY, VEC_TO_FIRST, VEC_TO_SECOND, VEC_FIRST_DROP,
		VEC_SECOND_DROP, VEC_MONITOR, VEC_NONE};
	int bits[7] = '{0, 1, 2, 5, 6, 7, 8};
	int bad_count = 0, checked = 0;
	////////////////////////////////////////
	// Clock, design and processor model
	always #20 pclk = ~pclk;
	aux_supply_irq_flags uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .active_supply(sup), .first_drop_stb(stb[0]),
		.second_drop_stb(stb[1]), .monitor_done_stb(stb[2]), .nmi_enable_cfg(cfg),
		.cpu_interrupt_master_enable(master_enable), .nmi_req(nmi), .irq_req(irq),
		.vector_out(vec));
	cpu_model cpu (.pclk, .presetn, .sw_enable, .master_enable);
	// Next pseudo random value
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic end_sim();
		$display("checked %0d, wrong %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic bad(input string m);
		bad_count++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		checked++;
		if (g !== e) bad(m);
	endtask
	// One APB transfer; a read notes its expected data, s pulses strobes in the access cycle
	task automatic apb(input logic w, input int a, input logic [31:0] d, input logic [2:0] s = 0);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a[11:0];
		pwdata <= d;
		if (!w) q.push_back(d);
		@(posedge pclk);
		penable <= 1;
		stb <= s;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel <= 0;
		penable <= 0;
		stb <= 0;
		if (n >= 50) begin
			bad("no ready");
			end_sim();
		end
	endtask
	// Wait for the outputs to follow, then compare vector and requests
	task automatic chk(input logic [15:0] v, input logic i, input logic m);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		cmp({vec, 14'h0000, irq, nmi}, {v, 14'h0000, i, m}, "vector or request");
		@(posedge pclk);
	endtask
	task automatic go(input supply_t s, input logic [15:0] e);
		sup <= s;
		ef = ef | e;
		repeat (3) @(posedge pclk);
	endtask
	// Compare each completed read with the oldest note
	always @(posedge pclk) begin
		// Every completed access answers with an error only off the map
		if (psel && penable && pready) begin
			checked++;
			if (pslverr !== (paddr > OFS_VECTOR)) bad("error response");
		end
		if (psel && penable && !pwrite && pready) begin
			checked++;
			if (q.size() == 0 || prdata !== q[0]) bad("read data");
			if (q.size() > 0) void'(q.pop_front());
		end
	end
	////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(0, OFS_FLAGS, 0);
		apb(0, OFS_ENABLES, 0);
		apb(0, OFS_VECTOR, 0);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			apb(1, OFS_ENABLES, {16'h0000, rnd & 16'hFFEF});
			apb(0, OFS_ENABLES, {16'h0000, rnd & 16'h00EF});
			rnd = lfsr(rnd);
			apb(1, OFS_FLAGS, {16'h0000, rnd & 16'hFFEF});
			apb(0, OFS_FLAGS, {16'h0000, rnd & 16'h01E7});
		end
		apb(1, OFS_VECTOR, 32'h0000_FFFF);
		apb(0, OFS_FLAGS, 0);
		$display("test register access done");
		sw_enable <= 1;
		apb(1, OFS_ENABLES, 32'h0000_00E7);
		go(SUPPLY_NONE, 0);
		go(SUPPLY_PRIMARY, 0);
		go(SUPPLY_FIRST, 16'h0102);
		go(SUPPLY_SECOND, 16'h0104);
		go(SUPPLY_PRIMARY, 16'h0101);
		apb(0, OFS_FLAGS, {16'h0000, ef}, 3'b111);
		ef = ef | 16'h00E0;
		for (int i = 0; i < 7; i++) begin
			chk(codes[i], i < 6, 0);
			ef = ef & ~(16'h0001 << bits[i]);
			apb(1, OFS_FLAGS, {16'h0000, ef});
		end
		$display("test events and priority done");
		apb(1, OFS_ENABLES, 32'h0000_0008);
		go(SUPPLY_FIRST, 16'h0102);
		chk(VEC_GLOBAL, 1, 0);
		sw_enable <= 0;
		chk(VEC_GLOBAL, 0, 0);
		sw_enable <= 1;
		cfg <= 1;
		chk(VEC_GLOBAL, 0, 1);
		apb(0, OFS_ENABLES, 32'h0000_0108);
		apb(1, OFS_VECTOR, 0);
		chk(VEC_NONE, 0, 0);
		go(SUPPLY_SECOND, 0);
		chk(VEC_GLOBAL, 0, 1);
		$display("test global switch done");
		apb(1, OFS_FLAGS, 0, 3'b001);
		apb(0, OFS_FLAGS, 32'h0000_0020);
		$display("test set wins done");
		apb(1, 16, 32'h0000_00FF);
		apb(0, 12, 0);
		apb(0, OFS_ENABLES, 32'h0000_0108);
		$display("test unmapped done");
		end_sim();
	end
endmodule // test_aux_supply_irq_flags
`default_nettype wire
